/* cpu_supervisor_pkg.sv */
// Shared constants and types for the CPU supervisor and reset watchdog.
// Assumes a single 20 MHz system clock and an APB register port.
package cpu_supervisor_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 20000;
   localparam int unsigned POR_VALID_US = 6000;
   localparam int unsigned BROWNOUT_MIN_US = 12000;
   localparam int unsigned CLK_LEAD_US = 2000;
   localparam int unsigned REDUCED_CLK_US = 2000;
   localparam int unsigned WDOG_HOLD_US = 12000;

   // Least times round up to whole cycles
   localparam int unsigned POR_VALID_CYC = (POR_VALID_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned BROWNOUT_MIN_CYC = (BROWNOUT_MIN_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned CLK_LEAD_CYC = (CLK_LEAD_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned REDUCED_CLK_CYC = (REDUCED_CLK_US * CLK_KHZ) / 1000;
   localparam int unsigned WDOG_HOLD_CYC = (WDOG_HOLD_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned TIMER_W = 20;

   // Host clock half periods in system cycles: 10 MHz and 625 kHz
   localparam int unsigned FULL_HALF_CYC = 1;
   localparam int unsigned REDUCED_HALF_CYC = 16;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WDOG_TIMEOUT_OFS = 8'h04;
   localparam logic [7:0] WDOG_RELOAD_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;

   // Control register fields
   localparam int unsigned THRESH_LSB = 0;
   localparam int unsigned THRESH_W = 6;
   localparam int unsigned LOCK_BIT = 8;
   localparam int unsigned CLKSEL_BIT = 16;
   // Timeout register fields
   localparam int unsigned TIMEOUT_W = 7;
   localparam int unsigned RUNNING_BIT = 8;
   // Status register fields
   localparam int unsigned CAUSE_LSB = 0;
   localparam int unsigned STATE_LSB = 8;

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   localparam logic [7:0] RELOAD_CODE_A = 8'h5A;
   localparam logic [7:0] RELOAD_CODE_B = 8'hC3;
   localparam int unsigned TICKS_PER_STEP_LOG2 = 8;
   localparam int unsigned WDOG_CNT_W = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] THRESH_RST = 6'h00;
   localparam logic [6:0] TIMEOUT_RST = 7'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_POR_HOLD = 3'b000,
      SEQ_POR_WAIT = 3'b001,
      SEQ_RUN = 3'b011,
      SEQ_BROWNOUT = 3'b010,
      SEQ_WDOG_HOLD = 3'b110
   } seqState_t;

   typedef enum logic [1:0] {
      HCLK_OFF = 2'b00,
      HCLK_FULL = 2'b01,
      HCLK_REDUCED = 2'b10
   } hostClkMode_t;

   typedef enum logic {
      WCLK_32K = 1'b0,
      WCLK_HOST = 1'b1
   } wdogClkSel_t;

   // Most recent reset source, one-hot
   typedef struct packed {
      logic wdogBadCode;
      logic wdogExpiry;
      logic brownout;
      logic powerOn;
   } resetCause_t;

   // Pin pair for a reset line
   typedef struct packed {
      logic level;
      logic oe;
   } resetPin_t;

endpackage

/* host_clock_gen.sv */
// Host clock output generator: divides the system clock to full or reduced
// rate, or holds the output low. Assumes mode changes are synchronous.
`timescale 1ns/1ps
`default_nettype none

module host_clock_gen #(
   parameter int unsigned FULL_HALF = cpu_supervisor_pkg::FULL_HALF_CYC,
   parameter int unsigned REDUCED_HALF = cpu_supervisor_pkg::REDUCED_HALF_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire cpu_supervisor_pkg::hostClkMode_t mode,
   output logic hostClk,
   output logic hostClkRise
);

   // ----------------------------------------------------------------
   // Half-period divider
   // ----------------------------------------------------------------
   logic [4:0] divCnt_q;
   logic [4:0] divCnt_d;
   logic hostClk_q;
   logic hostClk_d;
   logic [4:0] halfLen;
   logic halfDone;
   logic running;

   // Stopped clock parks low so the next start is a clean rising edge
   assign running = (mode != cpu_supervisor_pkg::HCLK_OFF);
   assign halfLen = (mode == cpu_supervisor_pkg::HCLK_REDUCED) ? 5'(REDUCED_HALF) : 5'(FULL_HALF);
   assign halfDone = (divCnt_q >= halfLen - 5'd1);
   assign divCnt_d = (!running || halfDone) ? 5'd0 : divCnt_q + 5'd1;
   assign hostClk_d = !running ? 1'b0 : (halfDone ? !hostClk_q : hostClk_q);

   // Registered clock and counter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         divCnt_q <= 5'd0;
         hostClk_q <= 1'b0;
      end else begin
         divCnt_q <= divCnt_d;
         hostClk_q <= hostClk_d;
      end
   end

   assign hostClk = hostClk_q;
   // One-cycle pulse in the cycle before the output goes high
   assign hostClkRise = running && halfDone && !hostClk_q;

endmodule

`default_nettype wire

/* cpu_supervisor_reset_watchdog.sv */
// CPU supervisor: reset sequencer, host clock gating, brownout threshold
// control, reset cause flags and an alternating-code watchdog on APB.
// Assumes supply comparator levels and the 32 kHz tick are synchronous.
// Function
// RULE1: Complementary resets, strong active, weak inactive
// RULE2: Six-bit code sets brownout threshold
// RULE3: Threshold from OTP, lockable against writes
// RULE4: Power-up release after 6 ms valid
// RULE5: Brownout release 6 ms valid, 12 ms minimum
// RULE6: Host clock runs 2 ms before release
// RULE7: Brownout: reduced clock, stopped after 2 ms
// RULE8: Assert resets within 5 us of crossing
// RULE9: Readable flags record last reset source
// RULE10: Watchdog disabled after any reset
// RULE11: Timeout write starts watchdog, locks settings
// RULE12: Watchdog clocked by 32 kHz or host clock
// RULE13: 32 kHz timeout 7.8125 ms steps to 1 s
// RULE14: Host clock timeout 256-cycle steps, pauses
// RULE15: Alternating 0x5A/0xC3 writes reload the timer
// RULE16: Expiry asserts system reset
// RULE17: Wrong or out-of-order code resets immediately
// RULE18: Watchdog reset lasts 12 ms
// RULE19: Host writes codes from separate routines
// RULE20: First code 0x5A, toggles, resets on reset
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cpu_supervisor_reset_watchdog #(
   parameter int unsigned POR_VALID = cpu_supervisor_pkg::POR_VALID_CYC,
   parameter int unsigned BROWNOUT_MIN = cpu_supervisor_pkg::BROWNOUT_MIN_CYC,
   parameter int unsigned CLK_LEAD = cpu_supervisor_pkg::CLK_LEAD_CYC,
   parameter int unsigned REDUCED_CLK = cpu_supervisor_pkg::REDUCED_CLK_CYC,
   parameter int unsigned WDOG_HOLD = cpu_supervisor_pkg::WDOG_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog and OTP side
   input wire logic supplyValid,
   input wire logic supplyLow,
   input wire logic [5:0] otpThreshold,
   input wire logic otpWriteProtect,
   input wire logic tick32k,
   input wire logic hostStopReq,
   output logic [5:0] brownout_threshold,
   // Host side
   output logic resetOut,
   output logic resetOutOe,
   output logic reset_out_low,
   output logic resetOutLowOe,
   output logic host_clock_output
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   localparam int unsigned TW = cpu_supervisor_pkg::TIMER_W;
   localparam int unsigned CW = cpu_supervisor_pkg::WDOG_CNT_W;

   // Saturating increment keeps long waits from wrapping
   function automatic logic [TW-1:0] satInc(input logic [TW-1:0] v);
      satInc = (&v) ? v : v + TW'(1);
   endfunction

   function automatic logic atLeast(input logic [TW-1:0] v, input int unsigned lim);
      atLeast = ({12'd0, v} >= 32'(lim));
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic setupPhase, accessPhase, wrStrobe, hitCtrl, hitTimeout, hitReload, hitStatus, mapped;

   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign hitCtrl = (paddr == cpu_supervisor_pkg::CTRL_OFS);
   assign hitTimeout = (paddr == cpu_supervisor_pkg::WDOG_TIMEOUT_OFS);
   assign hitReload = (paddr == cpu_supervisor_pkg::WDOG_RELOAD_OFS);
   assign hitStatus = (paddr == cpu_supervisor_pkg::STATUS_OFS);
   assign mapped = hitCtrl || hitTimeout || hitReload || hitStatus;
   // Zero wait states; unmapped accesses answer with an error
   assign pready = 1'b1;
   assign pslverr = accessPhase && !mapped;
   assign wrStrobe = accessPhase && pwrite && mapped;

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   cpu_supervisor_pkg::seqState_t state_q, state_d;
   logic [TW-1:0] validCnt_q, eventCnt_q, validCnt_d, eventCnt_d;
   logic wdogExpire, wdogBadWrite, wdogTrip, validDone, eventDone, holdDone, leadOk, enterReset;

   assign wdogTrip = wdogExpire || wdogBadWrite;
   assign validDone = atLeast(validCnt_q, POR_VALID - 1);
   assign eventDone = atLeast(eventCnt_q, BROWNOUT_MIN - 1);
   assign holdDone = atLeast(eventCnt_q, WDOG_HOLD - 1);
   // Clock lead window opens a full lead time before the later of the two deadlines
   assign leadOk = atLeast(validCnt_q, POR_VALID - CLK_LEAD)
      && atLeast(eventCnt_q, BROWNOUT_MIN - CLK_LEAD);

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         cpu_supervisor_pkg::SEQ_POR_HOLD: begin
            if (supplyValid) begin
               state_d = cpu_supervisor_pkg::SEQ_POR_WAIT;
            end
         end
         cpu_supervisor_pkg::SEQ_POR_WAIT: begin
            // RULE4 continuous valid supply
            if (!supplyValid) begin
               state_d = cpu_supervisor_pkg::SEQ_POR_HOLD;
            end else if (validDone) begin
               state_d = cpu_supervisor_pkg::SEQ_RUN;
            end
         end
         cpu_supervisor_pkg::SEQ_RUN: begin
            // RULE8 immediate brownout entry
            if (supplyLow) begin
               state_d = cpu_supervisor_pkg::SEQ_BROWNOUT;
            // RULE16 expiry trips reset
            end else if (wdogTrip) begin
               state_d = cpu_supervisor_pkg::SEQ_WDOG_HOLD;
            end
         end
         cpu_supervisor_pkg::SEQ_BROWNOUT: begin
            // RULE5 both delays met
            if (supplyValid && validDone && eventDone) begin
               state_d = cpu_supervisor_pkg::SEQ_RUN;
            end
         end
         cpu_supervisor_pkg::SEQ_WDOG_HOLD: begin
            if (supplyLow) begin
               state_d = cpu_supervisor_pkg::SEQ_BROWNOUT;
            // RULE18 twelve ms hold
            end else if (holdDone) begin
               state_d = cpu_supervisor_pkg::SEQ_RUN;
            end
         end
         default: begin
            state_d = cpu_supervisor_pkg::SEQ_POR_HOLD;
         end
      endcase
   end

   // Valid time restarts on any invalid sample; event time restarts on entry
   assign enterReset = (state_d != state_q)
      && (state_d == cpu_supervisor_pkg::SEQ_BROWNOUT || state_d == cpu_supervisor_pkg::SEQ_WDOG_HOLD);
   assign validCnt_d = supplyValid ? satInc(validCnt_q) : '0;
   assign eventCnt_d = enterReset ? '0 : satInc(eventCnt_q);

   // Sequencer registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= cpu_supervisor_pkg::SEQ_POR_HOLD;
         validCnt_q <= '0;
         eventCnt_q <= '0;
      end else begin
         state_q <= state_d;
         validCnt_q <= validCnt_d;
         eventCnt_q <= eventCnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset pins and host clock
   // ----------------------------------------------------------------
   logic resetActive_q, resetActive_d, hostClkRise;
   cpu_supervisor_pkg::hostClkMode_t clkMode;

   // RULE8 registered one cycle after crossing
   assign resetActive_d = (state_d != cpu_supervisor_pkg::SEQ_RUN);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         resetActive_q <= 1'b1;
      end else begin
         resetActive_q <= resetActive_d;
      end
   end

   // RULE1 drive only while asserted, weak pull otherwise
   assign resetOut = resetActive_q;
   assign resetOutOe = resetActive_q;
   assign reset_out_low = !resetActive_q;
   assign resetOutLowOe = resetActive_q;

   // RULE6 clock leads release; RULE7 reduced then stopped
   always_comb begin
      clkMode = cpu_supervisor_pkg::HCLK_OFF;
      unique case (state_q)
         cpu_supervisor_pkg::SEQ_POR_WAIT: begin
            if (atLeast(validCnt_q, POR_VALID - CLK_LEAD)) begin
               clkMode = cpu_supervisor_pkg::HCLK_FULL;
            end
         end
         cpu_supervisor_pkg::SEQ_BROWNOUT: begin
            if (supplyValid && leadOk) begin
               clkMode = cpu_supervisor_pkg::HCLK_FULL;
            end else if (!atLeast(eventCnt_q, REDUCED_CLK)) begin
               clkMode = cpu_supervisor_pkg::HCLK_REDUCED;
            end
         end
         cpu_supervisor_pkg::SEQ_RUN: begin
            if (!hostStopReq) begin
               clkMode = cpu_supervisor_pkg::HCLK_FULL;
            end
         end
         cpu_supervisor_pkg::SEQ_WDOG_HOLD: begin
            clkMode = cpu_supervisor_pkg::HCLK_FULL;
         end
         default: begin
            clkMode = cpu_supervisor_pkg::HCLK_OFF;
         end
      endcase
   end

   host_clock_gen u_host_clock_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .mode(clkMode),
      .hostClk(host_clock_output),
      .hostClkRise(hostClkRise)
   );

   // ----------------------------------------------------------------
   // Brownout threshold
   // ----------------------------------------------------------------
   logic [5:0] thresh_q;
   logic threshLock_q, otpLoad_q, threshWrite;

   // RULE3 writes blocked by either lock
   assign threshWrite = wrStrobe && hitCtrl && !threshLock_q && !otpWriteProtect;

   // OTP default loads once after release
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thresh_q <= cpu_supervisor_pkg::THRESH_RST;
         threshLock_q <= 1'b0;
         otpLoad_q <= 1'b1;
      end else begin
         otpLoad_q <= 1'b0;
         if (otpLoad_q) begin
            thresh_q <= otpThreshold;
         end else if (threshWrite) begin
            thresh_q <= pwdata[cpu_supervisor_pkg::THRESH_LSB +: cpu_supervisor_pkg::THRESH_W];
            threshLock_q <= pwdata[cpu_supervisor_pkg::LOCK_BIT];
         end
      end
   end

   // RULE2 code drives the comparator reference
   assign brownout_threshold = thresh_q;

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   logic wdogRun_q, expectB_q, wdogTick, reloadWrite, codeOk, startWrite;
   logic [6:0] timeout_q;
   cpu_supervisor_pkg::wdogClkSel_t clkSel_q;
   logic [CW-1:0] wdogCnt_q, reloadValue;
   logic [7:0] expectCode;

   // RULE13 RULE14 (value+1) steps of 256 ticks
   assign reloadValue = CW'({1'b0, timeout_q} + 8'd1) << cpu_supervisor_pkg::TICKS_PER_STEP_LOG2;
   // RULE12 tick source; host clock ticks pause while it is stopped
   assign wdogTick = (clkSel_q == cpu_supervisor_pkg::WCLK_HOST) ? hostClkRise : tick32k;
   // RULE20 expected code follows alternation
   assign expectCode = expectB_q ? cpu_supervisor_pkg::RELOAD_CODE_B : cpu_supervisor_pkg::RELOAD_CODE_A;
   assign reloadWrite = wrStrobe && hitReload && wdogRun_q && !resetActive_q;
   assign codeOk = (pwdata[7:0] == expectCode);
   // RULE17 bad code trips immediately
   assign wdogBadWrite = reloadWrite && !codeOk;
   assign wdogExpire = wdogRun_q && wdogTick && (wdogCnt_q == CW'(1));
   // RULE11 timeout write starts and locks
   assign startWrite = wrStrobe && hitTimeout && !wdogRun_q && !resetActive_q;

   always_ff @(posedge clk_sys) begin
      // RULE10 any reset disables the watchdog
      if (rst || resetActive_q) begin
         wdogRun_q <= 1'b0;
         timeout_q <= cpu_supervisor_pkg::TIMEOUT_RST;
         clkSel_q <= cpu_supervisor_pkg::WCLK_32K;
         expectB_q <= 1'b0;
         wdogCnt_q <= '0;
      end else if (startWrite) begin
         wdogRun_q <= 1'b1;
         timeout_q <= pwdata[cpu_supervisor_pkg::TIMEOUT_W-1:0];
         wdogCnt_q <= CW'({1'b0, pwdata[6:0]} + 8'd1) << cpu_supervisor_pkg::TICKS_PER_STEP_LOG2;
      end else begin
         // RULE11 clock source fixed once running
         if (wrStrobe && hitCtrl && !wdogRun_q) begin
            clkSel_q <= cpu_supervisor_pkg::wdogClkSel_t'(pwdata[cpu_supervisor_pkg::CLKSEL_BIT]);
         end
         // RULE15 correct code reloads and toggles
         if (reloadWrite && codeOk) begin
            wdogCnt_q <= reloadValue;
            expectB_q <= !expectB_q;
         end else if (wdogRun_q && wdogTick && wdogCnt_q != '0) begin
            wdogCnt_q <= wdogCnt_q - CW'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags
   // ----------------------------------------------------------------
   cpu_supervisor_pkg::resetCause_t cause_q;

   // RULE9 most recent source overwrites
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cause_q <= 4'h1;
      end else if (enterReset && state_d == cpu_supervisor_pkg::SEQ_BROWNOUT) begin
         cause_q <= 4'h2;
      end else if (enterReset) begin
         cause_q <= {wdogBadWrite, !wdogBadWrite, 2'h0};
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] rdCtrl, rdTimeout, rdStatus, rdMux;

   assign rdCtrl = {15'd0, clkSel_q, 7'd0, threshLock_q, 2'd0, thresh_q};
   assign rdTimeout = {23'd0, wdogRun_q, 1'b0, timeout_q};
   assign rdStatus = {21'd0, state_q, 4'd0, cause_q};
   // Reload register reads as zero so the code is never exposed
   assign rdMux = hitCtrl ? rdCtrl : (hitTimeout ? rdTimeout : (hitStatus ? rdStatus : 32'h0000_0000));

   // Captured in setup so data is from a flip-flop during access
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setupPhase && !pwrite) begin
         prdata <= rdMux;
      end
   end

endmodule

`default_nettype wire

/* cpu_supervisor_reset_watchdog_asserts.sv */
// Port-level checks for the CPU supervisor.
// Assumes one clock domain; bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module cpu_supervisor_reset_watchdog_asserts #(
   parameter int unsigned POR_VALID = 60,
   parameter int unsigned CLK_LEAD = 20,
   parameter int unsigned REDUCED_CLK = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic supplyLow,
   input wire logic otpWriteProtect,
   input wire logic [5:0] brownout_threshold,
   input wire logic resetOut,
   input wire logic resetOutOe,
   input wire logic reset_out_low,
   input wire logic resetOutLowOe,
   input wire logic host_clock_output
);
   // ----------------------------------------
   // Helper run-length counters
   // ----------------------------------------
   logic [19:0] hiCnt_q, runCnt_q, lowCnt_q;
   logic clkPrev_q;
   logic unmapped;
   // Only the four aligned words up to 0x0C exist
   assign unmapped = (paddr[1:0] != 2'b00) || (paddr > 8'h0C);
   // Cleared in reset
   always_ff @(posedge clk_sys) begin
      clkPrev_q <= host_clock_output;
      hiCnt_q <= rst ? '0 : (resetOut ? hiCnt_q + 1'b1 : '0);
      runCnt_q <= rst ? '0 : ((host_clock_output != clkPrev_q) ? runCnt_q + 1'b1 : '0);
      lowCnt_q <= rst ? '0 : (supplyLow ? lowCnt_q + 1'b1 : '0);
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_reset_pins: assert property (resetOutOe == resetOut && resetOutLowOe == resetOut
      && reset_out_low == !resetOut) else $error("reset pins disagree");
   chk_low_assert: assert property (supplyLow |-> ##[1:2] resetOut)
      else $error("reset late after low supply");
   chk_clock_lead: assert property ($fell(resetOut) |-> runCnt_q >= CLK_LEAD - 1)
      else $error("host clock not running before release");
   chk_clock_stop: assert property (lowCnt_q > REDUCED_CLK + 4 |-> !host_clock_output
      && $stable(host_clock_output)) else $error("host clock still running in brownout");
   chk_min_hold: assert property ($fell(resetOut) |-> hiCnt_q >= POR_VALID)
      else $error("reset released too early");
   chk_thresh_guard: assert property ($changed(brownout_threshold) |-> $past(rst) || $past(rst, 2)
      || ($past(psel && penable && pwrite && paddr == 8'h00) && !$past(otpWriteProtect)))
      else $error("threshold changed without write");
   chk_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("access phase without ready");
   chk_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
      else $error("error response mismatch");
endmodule
bind cpu_supervisor_reset_watchdog cpu_supervisor_reset_watchdog_asserts #(.POR_VALID(POR_VALID),
   .CLK_LEAD(CLK_LEAD), .REDUCED_CLK(REDUCED_CLK)) chk_inst (.clk_sys(clk_sys), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .supplyLow(supplyLow), .otpWriteProtect(otpWriteProtect), .brownout_threshold(brownout_threshold),
   .resetOut(resetOut), .resetOutOe(resetOutOe), .reset_out_low(reset_out_low),
   .resetOutLowOe(resetOutLowOe), .host_clock_output(host_clock_output));
`default_nettype wire

/* host_mcu_model.sv */
// Host side model: resolves the reset pins and counts host clock edges.
// Assumes weak pulls on both reset lines when undriven.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
   input wire logic resetOut,
   input wire logic resetOutOe,
   input wire logic reset_out_low,
   input wire logic resetOutLowOe,
   input wire logic host_clock_output,
   output logic rstHiPin,
   output logic rstLoPin,
   output var int clkRises
);
   assign rstHiPin = resetOutOe ? resetOut : 1'b0;
   assign rstLoPin = resetOutLowOe ? reset_out_low : 1'b1;
   // Rising edges seen by the host
   initial clkRises = 0;
   always @(posedge host_clock_output) clkRises++;
endmodule
`default_nettype wire

/* tb_cpu_supervisor_reset_watchdog.sv */
// Self-checking bench for the supervisor with shortened timing counts.
// Assumes the checker is bound and the host model resolves the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_supervisor_reset_watchdog;
   localparam int PV = 60, BM = 120, WH = 120;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e; logic s;} row_t;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic supplyValid = 0, supplyLow = 0, tick32k = 0, tickEn = 0, resetOut, resetOutOe;
   logic reset_out_low, resetOutLowOe, host_clock_output, rstHiPin, rstLoPin;
   logic [5:0] brownout_threshold;
   int error_cnt = 0, n_compared = 0, n, m, clkRises;
   time t0;
   row_t rows[9] = '{'{1, 8'h00, 32'h0000_002A, 32'h0, 0}, '{0, 8'h00, 32'h0, 32'h0000_002A, 0},
      '{0, 8'h10, 32'h0, 32'h0, 1}, '{1, 8'h00, 32'h0000_0115, 32'h0, 0}, '{1, 8'h00, 32'h0000_003F, 32'h0, 0},
      '{0, 8'h00, 32'h0, 32'h0000_0115, 0}, '{0, 8'h08, 32'h0, 32'h0, 0}, '{0, 8'h0C, 32'h0, 32'h0000_0301, 0},
      '{0, 8'h04, 32'h0, 32'h0, 0}};
   cpu_supervisor_reset_watchdog #(.POR_VALID(PV), .BROWNOUT_MIN(BM), .CLK_LEAD(20), .REDUCED_CLK(40),
      .WDOG_HOLD(WH)) cpu_supervisor_reset_watchdog_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .supplyValid(supplyValid), .supplyLow(supplyLow), .otpThreshold(6'h15),
      .otpWriteProtect(1'b0), .tick32k(tick32k), .hostStopReq(1'b0), .brownout_threshold(brownout_threshold),
      .resetOut(resetOut), .resetOutOe(resetOutOe), .reset_out_low(reset_out_low),
      .resetOutLowOe(resetOutLowOe), .host_clock_output(host_clock_output));
   host_mcu_model host_mcu_model_inst (.resetOut(resetOut), .resetOutOe(resetOutOe),
      .reset_out_low(reset_out_low), .resetOutLowOe(resetOutLowOe), .host_clock_output(host_clock_output),
      .rstHiPin(rstHiPin), .rstLoPin(rstLoPin), .clkRises(clkRises));
   // 20 MHz clock; fast slow tick keeps runs short
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) tick32k <= tickEn & ~tick32k;
   task automatic give_verdict;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin error_cnt++; give_verdict(); end
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk_sys);
   endtask
   // Bounded wait for a reset level
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (resetOut !== lvl) begin
         @(negedge clk_sys) n++;
         if (n > lim) begin error_cnt++; give_verdict(); end
      end
      @(posedge clk_sys);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 0;
      repeat (3) @(posedge clk_sys);
      chk32(brownout_threshold, 32'h15);
      chk32({rstHiPin, rstLoPin}, 2'b10);
      supplyValid <= 1;
      wait_rst(0, 300);
      chk32(32'(n >= PV - 4), 1);
      chk32({rstHiPin, rstLoPin}, 2'b01);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk32(rd, rows[i].e);
         chk32(err, rows[i].s);
      end
      tickEn <= 1;
      apb(1, 8'h04, 32'h0);
      apb(1, 8'h04, 32'h0000_0005);
      apb(0, 8'h04, 32'h0);
      chk32(rd, 32'h0000_0100);
      apb(1, 8'h08, 32'h0000_005A);
      apb(1, 8'h08, 32'h0000_00C3);
      chk32(resetOut, 0);
      apb(1, 8'h08, 32'h0000_00C3);
      wait_rst(1, 3);
      apb(0, 8'h0C, 32'h0);
      chk32(rd, 32'h0000_0608);
      wait_rst(0, 300);
      chk32(32'(n > WH - 10 && n < WH + 3), 1);
      apb(0, 8'h04, 32'h0);
      chk32(rd, 32'h0);
      apb(1, 8'h04, 32'h0);
      wait_rst(1, 2000);
      chk32(32'(n > 500 && n < 530), 1);
      apb(0, 8'h0C, 32'h0);
      chk32(rd, 32'h0000_0604);
      wait_rst(0, 300);
      supplyLow <= 1; supplyValid <= 0;
      wait_rst(1, 3);
      t0 = $time; m = clkRises;
      repeat (34) @(posedge clk_sys);
      chk32(32'(clkRises > m), 1);
      repeat (30) @(posedge clk_sys) m = clkRises;
      repeat (10) @(posedge clk_sys);
      chk32(clkRises, m);
      supplyLow <= 0; supplyValid <= 1;
      wait_rst(0, 400);
      chk32(32'(($time - t0) / 50 >= BM - 2), 1);
      apb(0, 8'h0C, 32'h0);
      chk32(rd, 32'h0000_0302);
      give_verdict();
   end
endmodule
`default_nettype wire
